//--- inc/rcwdt_pkg.sv
package rcwdt_pkg;

	// ---------------------------------------------------------------
	// register map (word indices, one aligned word each)
	// ---------------------------------------------------------------
	// 0xFFFF is not a multiple of four: offsets are indices, address = 4 * index
	localparam logic [15:0] IDX_SERVICE   = 16'hFFFF;
	localparam logic [15:0] IDX_CONFIG    = 16'h0000;
	localparam logic [15:0] IDX_CAUSE     = 16'h0001;
	localparam logic [15:0] IDX_IRQ_STAT  = 16'h0002;
	localparam logic [15:0] IDX_IRQ_MASK  = 16'h0003;
	localparam logic [15:0] IDX_STATUS    = 16'h0004;

	// ---------------------------------------------------------------
	// field layout
	// ---------------------------------------------------------------
	localparam int CFG_RATE_BIT    = 0; // timeout_length_select
	localparam int CFG_DISABLE_BIT = 1; // watchdog_disable_bit
	localparam int CFG_STOPEN_BIT  = 2; // stop instruction enabled
	localparam int CAUSE_WDOG_BIT  = 0;
	localparam int CAUSE_ILOP_BIT  = 1;
	localparam int CAUSE_POR_BIT   = 2;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] CONFIG_RESET  = 8'h00;
	localparam logic [7:0] CAUSE_RESET   = 8'h04;
	localparam logic [7:0] MASK_RESET    = 8'h00;
	localparam logic [7:0] VECTOR_LOW    = 8'h00; // arbitrary reset vector low byte

	// ---------------------------------------------------------------
	// widths and timing
	// ---------------------------------------------------------------
	localparam int PRESC_W        = 12;
	localparam int WDOG_W         = 6;
	localparam int PRESC_KEEP     = 5;  // bits below this minus one (3..0) survive a service
	localparam int TAP_SHORT      = 7;  // 2^13 - 2^4 overall
	localparam int TAP_LONG       = 12; // 2^18 - 2^4 overall
	localparam int RST_PULSE_CYC  = 32;
	localparam int OVF_EARLY      = 16; // overflow comes 2^4 cycles before a full count
	localparam int POR_CLR_CYC    = 4096;
	localparam logic [3:0] SHORT_EXP = 4'hD;
	localparam logic [4:0] LONG_EXP  = 5'h12;

	// ---------------------------------------------------------------
	// ahb constants
	// ---------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

	typedef enum {
		RCWDT_RUN,
		RCWDT_HOLD_RST
	} rcwdt_state_t;

endpackage

//--- hdl/rcwdt_top.sv
`timescale 1ns/1ns
// Functional notes
// - watchdog is 6-bit counter ticked by a 12-bit prescaler on internal clock
// - unserviced watchdog overflows and resets after 262128 or 8176 cycles
// - select bit set gives 2^13-2^4, clear gives 2^18-2^4; resets to zero
// - any write to service register clears counter and prescaler bits 11..4
// - read of service register returns reset vector low byte, counter untouched
// - overflow drives reset low 32 cycles and sets watchdog cause flag
// - stop instruction clears prescaler; clock gated off during stop mode
// - power-on logic clears prescaler 4096 cycles after power-up
// - any internal reset clears both prescaler and counter
// - reset vector fetch clears the prescaler
// - disable bit 1 disables whole watchdog, 0 enables it
// - monitor entered with test voltage: disabled while voltage on irq or reset pin
// - monitor entered by blank vectors: disabled until next power-on reset
// - in break state, test voltage on reset pin disables the watchdog
// - watchdog keeps counting in wait mode
// - with stop disabled, stop instruction causes illegal-opcode reset instead
// - overflow also sets an event bit that raises IRQ when enabled in the irq mask
module rcwdt_top
	import rcwdt_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic        POR_N,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic        HSEL,
	input  wire logic        HREADY,
	input  wire logic [31:0] HWDATA,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        STOP_EXEC,
	input  wire logic        STOP_MODE,
	input  wire logic        VECTOR_FETCH,
	input  wire logic        INTERNAL_RESET,
	input  wire logic        TST_ON_RST_PIN,
	input  wire logic        TST_ON_IRQ_PIN,
	input  wire logic        MONITOR_MODE,
	input  wire logic        MONITOR_BY_TST,
	input  wire logic        BREAK_STATE,
	output logic             RST_PIN_N,
	output logic             RST_PIN_OE,
	output logic             ILLEGAL_OP_RST,
	output logic             IRQ
);
	import rcwdt_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [2:0]         sy_tst_rst;   // three-stage synchronisers
		logic [2:0]         sy_tst_irq;
		logic [2:0]         sy_mon;
		logic [2:0]         sy_montst;
		logic [2:0]         sy_brk;
		logic               tst_rst;
		logic               tst_irq;
		logic               mon;
		logic               montst;
		logic               brk;
		logic               mon_latched;  // blank-vector monitor entry
		logic [PRESC_W-1:0] presc;
		logic [WDOG_W-1:0]  wdog;
		logic [12:0]        por_cnt;
		logic               por_done;
		rcwdt_state_t       st;
		logic [5:0]         pulse_cnt;
		logic [7:0]         config_r;
		logic [7:0]         cause;
		logic [7:0]         irq_stat;
		logic [7:0]         irq_mask;
		logic               dp_act;       // data phase pending
		logic               dp_write;
		logic [15:0]        dp_idx;
		logic [31:0]        rdata;
		logic               rst_n_o;
		logic               rst_oe_o;
		logic               ilop_o;
		logic               irq_o;
	} rcwdt_regs_t;

	rcwdt_regs_t r_reg;
	rcwdt_regs_t r_next;

	// agreement of last two stages counts as a change
	function automatic logic sy_val(input logic [2:0] s, input logic prev);
		sy_val = (s[2] == s[1]) ? s[1] : prev;
	endfunction

	// ---------------------------------------------------------------
	// combinational next state
	// ---------------------------------------------------------------
	logic        addr_ok;
	logic        wr_service;
	logic        wr_cfg;
	logic        wdog_dis;
	logic        presc_tick;
	logic        overflow;
	logic        presc_clr;
	logic        ilop;
	logic [15:0] a_idx;
	logic [7:0]  events;

	always_comb begin
		r_next = r_reg;
		a_idx = HADDR[17:2];
		addr_ok = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ);

		// synchronise pin qualifiers
		r_next.sy_tst_rst = {r_reg.sy_tst_rst[1:0], TST_ON_RST_PIN};
		r_next.sy_tst_irq = {r_reg.sy_tst_irq[1:0], TST_ON_IRQ_PIN};
		r_next.sy_mon     = {r_reg.sy_mon[1:0], MONITOR_MODE};
		r_next.sy_montst  = {r_reg.sy_montst[1:0], MONITOR_BY_TST};
		r_next.sy_brk     = {r_reg.sy_brk[1:0], BREAK_STATE};
		r_next.tst_rst = sy_val(r_reg.sy_tst_rst, r_reg.tst_rst);
		r_next.tst_irq = sy_val(r_reg.sy_tst_irq, r_reg.tst_irq);
		r_next.mon     = sy_val(r_reg.sy_mon, r_reg.mon);
		r_next.montst  = sy_val(r_reg.sy_montst, r_reg.montst);
		r_next.brk     = sy_val(r_reg.sy_brk, r_reg.brk);

		// blank-vector monitor entry sticks until power-on
		if (r_reg.mon && !r_reg.montst)
			r_next.mon_latched = 1'b1;

		// disable qualifiers
		wdog_dis = r_reg.config_r[CFG_DISABLE_BIT]
			|| (r_reg.mon && r_reg.montst && (r_reg.tst_irq || r_reg.tst_rst))
			|| r_reg.mon_latched
			|| (r_reg.brk && r_reg.tst_rst);

		// bus data phase
		wr_service = r_reg.dp_act && r_reg.dp_write && r_reg.dp_idx == IDX_SERVICE;
		wr_cfg     = r_reg.dp_act && r_reg.dp_write && r_reg.dp_idx == IDX_CONFIG;
		if (wr_cfg)
			r_next.config_r = HWDATA[7:0];
		if (r_reg.dp_act && r_reg.dp_write && r_reg.dp_idx == IDX_IRQ_MASK)
			r_next.irq_mask = HWDATA[7:0];

		// read data for the next data phase
		r_next.dp_act = addr_ok;
		r_next.dp_write = HWRITE;
		r_next.dp_idx = a_idx;
		r_next.rdata = 32'h0000_0000;
		if (addr_ok && !HWRITE) begin
			unique case (a_idx)
				IDX_SERVICE:  r_next.rdata = {24'h000000, VECTOR_LOW};
				IDX_CONFIG:   r_next.rdata = {24'h000000, r_reg.config_r};
				IDX_CAUSE:    r_next.rdata = {24'h000000, r_reg.cause};
				IDX_IRQ_STAT: r_next.rdata = {24'h000000, r_reg.irq_stat};
				IDX_IRQ_MASK: r_next.rdata = {24'h000000, r_reg.irq_mask};
				IDX_STATUS:   r_next.rdata = {16'h0000, 2'b00, r_reg.wdog,
					2'b00, wdog_dis, r_reg.st == RCWDT_HOLD_RST, r_reg.por_done,
					r_reg.mon_latched, r_reg.brk, r_reg.mon};
				default:      r_next.rdata = 32'h0000_0000;
			endcase
		end

		// power-on prescaler clear
		presc_clr = 1'b0;
		if (!r_reg.por_done) begin
			r_next.por_cnt = r_reg.por_cnt + 13'h0001;
			if (r_reg.por_cnt == 13'(POR_CLR_CYC - 1)) begin
				r_next.por_done = 1'b1;
				presc_clr = 1'b1;
			end
		end

		// prescaler and counter
		presc_tick = r_reg.config_r[CFG_RATE_BIT]
			? (r_reg.presc[TAP_SHORT-1:0] == {TAP_SHORT{1'b1}})
			: (r_reg.presc == {PRESC_W{1'b1}});
		overflow = 1'b0;
		if (!STOP_MODE && !wdog_dis && r_reg.st == RCWDT_RUN) begin
			r_next.presc = r_reg.presc + 12'h001;
			if (r_reg.config_r[CFG_RATE_BIT]) begin
				if (r_reg.presc[TAP_SHORT-1:0] == {TAP_SHORT{1'b1}}) begin
					r_next.presc[PRESC_W-1:TAP_SHORT] = '0;
					r_next.wdog = r_reg.wdog + 6'h01;
				end
			end else if (presc_tick) begin
				r_next.wdog = r_reg.wdog + 6'h01;
			end
			// overflow 2^4 cycles before the last counter tick would fall
			if (r_reg.wdog == {WDOG_W{1'b1}} && (r_reg.config_r[CFG_RATE_BIT]
				? r_reg.presc[TAP_SHORT-1:0] == TAP_SHORT'(2**TAP_SHORT - 1 - OVF_EARLY)
				: r_reg.presc == PRESC_W'(2**PRESC_W - 1 - OVF_EARLY)))
				overflow = 1'b1;
		end
		// service: clear counter and upper prescaler bits
		if (wr_service) begin
			r_next.wdog = '0;
			r_next.presc[PRESC_W-1:PRESC_KEEP-1] = '0;
		end
		ilop = STOP_EXEC && !r_reg.config_r[CFG_STOPEN_BIT];
		if ((STOP_EXEC && !ilop) || VECTOR_FETCH || presc_clr)
			r_next.presc = '0;
		if (wdog_dis) begin
			r_next.presc = '0;
			r_next.wdog = '0;
		end

		// reset pulse sequencer
		unique case (r_reg.st)
			RCWDT_RUN: begin
				if (overflow) begin
					r_next.st = RCWDT_HOLD_RST;
					r_next.pulse_cnt = '0;
					r_next.cause[CAUSE_WDOG_BIT] = 1'b1;
				end
			end
			RCWDT_HOLD_RST: begin
				r_next.pulse_cnt = r_reg.pulse_cnt + 6'h01;
				if (r_reg.pulse_cnt == 6'(RST_PULSE_CYC - 1)) begin
					r_next.st = RCWDT_RUN;
					r_next.presc = '0;
					r_next.wdog = '0;
				end
			end
		endcase
		if (ilop)
			r_next.cause[CAUSE_ILOP_BIT] = 1'b1;
		if (INTERNAL_RESET) begin
			r_next.presc = '0;
			r_next.wdog = '0;
		end

		// sticky event bits; read clears, a new event wins
		events = {6'h00, ilop, overflow};
		if (r_reg.dp_act && !r_reg.dp_write && r_reg.dp_idx == IDX_IRQ_STAT)
			r_next.irq_stat = 8'h00;
		r_next.irq_stat = r_next.irq_stat | events;

		// registered outputs; overflow gives reset and, when unmasked, IRQ
		r_next.rst_n_o  = !(r_next.st == RCWDT_HOLD_RST);
		r_next.rst_oe_o = r_next.st == RCWDT_HOLD_RST;
		r_next.ilop_o   = ilop;
		r_next.irq_o    = |(r_next.irq_stat & r_reg.irq_mask);
	end

	// ---------------------------------------------------------------
	// register update
	// ---------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			r_reg <= '0;
			r_reg.st <= RCWDT_RUN;
			r_reg.config_r <= CONFIG_RESET;
			r_reg.irq_mask <= MASK_RESET;
			r_reg.rst_n_o <= 1'b1;
			r_reg.cause <= 8'h00;
		end else begin
			r_reg <= r_next;
			if (!POR_N) begin
				r_reg.por_cnt <= '0;     // power-on restarts delay and monitor latch
				r_reg.por_done <= 1'b0;
				r_reg.mon_latched <= 1'b0;
				r_reg.cause <= CAUSE_RESET;
			end
		end
	end

	// outputs straight from flip-flops; HREADYOUT and HRESP tied constant
	assign HRDATA         = r_reg.rdata;
	assign HREADYOUT      = 1'b1;
	assign HRESP          = 1'b0;
	assign RST_PIN_N      = r_reg.rst_n_o;
	assign RST_PIN_OE     = r_reg.rst_oe_o;
	assign ILLEGAL_OP_RST = r_reg.ilop_o;
	assign IRQ            = r_reg.irq_o;

endmodule

//--- test/rcwdt_properties.sv
`timescale 1ns/1ns
module rcwdt_properties
	import rcwdt_pkg::*;
(
	input wire logic        CLK,
	input wire logic        RSTN,
	input wire logic [31:0] HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic        HSEL,
	input wire logic        HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic        HREADYOUT,
	input wire logic        HRESP,
	input wire logic        STOP_EXEC,
	input wire logic        STOP_MODE,
	input wire logic        TST_ON_RST_PIN,
	input wire logic        TST_ON_IRQ_PIN,
	input wire logic        MONITOR_MODE,
	input wire logic        MONITOR_BY_TST,
	input wire logic        BREAK_STATE,
	input wire logic        RST_PIN_N,
	input wire logic        RST_PIN_OE,
	input wire logic        ILLEGAL_OP_RST
);
	logic [5:0]  low_cnt;
	logic [17:0] since;
	logic        svc_wr;
	logic        svc_rd;
	wire         take = HSEL && HREADY && HTRANS[1] && (HADDR == 32'h0003FFFC);
	// pulse length, cycles since service, service data phases
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			low_cnt <= 6'h00;
			since   <= 18'h00000;
			svc_wr  <= 1'b0;
			svc_rd  <= 1'b0;
		end else begin
			low_cnt <= RST_PIN_N ? 6'h00 : low_cnt + 6'h01;
			since   <= svc_wr ? 18'h00000 : since + {17'h0, since != 18'h3FFFF};
			svc_wr  <= take && HWRITE;
			svc_rd  <= take && !HWRITE;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	AST_PULSE_LEN: assert property (RST_PIN_N && low_cnt != 6'h00 |-> low_cnt == 6'h20)
		else $error("reset pulse length wrong");
	AST_OE_LOW: assert property (RST_PIN_OE == !RST_PIN_N)
		else $error("pin enable not tied to low drive");
	AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
		else $error("bus not ready or not okay");
	AST_ILOP_CAUSE: assert property (ILLEGAL_OP_RST |-> $past(STOP_EXEC))
		else $error("illegal op reset without stop");
	AST_SVC_PERIOD: assert property ($fell(RST_PIN_N) |-> since >= 18'h01FD0)
		else $error("overflow too soon after service");
	AST_BRK_OFF: assert property ((BREAK_STATE && TST_ON_RST_PIN)[*8] |-> !$fell(RST_PIN_N))
		else $error("overflow in break with test voltage");
	AST_MON_OFF: assert property ((MONITOR_MODE && MONITOR_BY_TST && TST_ON_IRQ_PIN)[*8]
		|-> !$fell(RST_PIN_N))
		else $error("overflow in monitor mode");
	AST_STOP_OFF: assert property (STOP_MODE[*8] |-> !$fell(RST_PIN_N))
		else $error("overflow in stop mode");
	AST_VEC_READ: assert property (svc_rd |-> HRDATA == {24'h000000, VECTOR_LOW})
		else $error("service read not vector byte");
	AST_HIGH_ZERO: assert property (HRDATA[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	// main scenarios
	cover property ($fell(RST_PIN_N));
	cover property (svc_wr);
	cover property (ILLEGAL_OP_RST);
endmodule

bind rcwdt_top rcwdt_properties chk_i (.CLK(CLK), .RSTN(RSTN), .HADDR(HADDR), .HTRANS(HTRANS),
	.HWRITE(HWRITE), .HSEL(HSEL), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
	.HRESP(HRESP), .STOP_EXEC(STOP_EXEC), .STOP_MODE(STOP_MODE), .TST_ON_RST_PIN(TST_ON_RST_PIN),
	.TST_ON_IRQ_PIN(TST_ON_IRQ_PIN), .MONITOR_MODE(MONITOR_MODE), .MONITOR_BY_TST(MONITOR_BY_TST),
	.BREAK_STATE(BREAK_STATE), .RST_PIN_N(RST_PIN_N), .RST_PIN_OE(RST_PIN_OE),
	.ILLEGAL_OP_RST(ILLEGAL_OP_RST));

//--- test/tb.sv
`timescale 1ns/1ns
module tb;
	import rcwdt_pkg::*;
	logic        CLK, RSTN, HWRITE, HSEL, STOP_EXEC, STOP_MODE, INTERNAL_RESET;
	logic        TST_ON_RST_PIN, TST_ON_IRQ_PIN, MONITOR_MODE, MONITOR_BY_TST, BREAK_STATE;
	logic [31:0] HADDR, HWDATA, HRDATA, r;
	logic [1:0]  HTRANS;
	logic        HREADYOUT, HRESP, RST_PIN_N, RST_PIN_OE, ILLEGAL_OP_RST, IRQ;
	int          err_count, total_checks;
	rcwdt_top dut (.CLK(CLK), .RSTN(RSTN), .POR_N(1'b1), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(3'h2), .HSEL(HSEL), .HREADY(HREADYOUT), .HWDATA(HWDATA),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .STOP_EXEC(STOP_EXEC),
		.STOP_MODE(STOP_MODE), .VECTOR_FETCH(1'b0), .INTERNAL_RESET(INTERNAL_RESET),
		.TST_ON_RST_PIN(TST_ON_RST_PIN), .TST_ON_IRQ_PIN(TST_ON_IRQ_PIN),
		.MONITOR_MODE(MONITOR_MODE), .MONITOR_BY_TST(MONITOR_BY_TST), .BREAK_STATE(BREAK_STATE),
		.RST_PIN_N(RST_PIN_N), .RST_PIN_OE(RST_PIN_OE), .ILLEGAL_OP_RST(ILLEGAL_OP_RST), .IRQ(IRQ));
	// 8 ns clock
	always #4 CLK = ~CLK;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task hung;
		err_count++;
		$display("[ERR] %0t wait ran out", $time);
		results();
	endtask
	// bounded wait for the slave ready
	task rdy;
		int i;
		for (i = 0; i < 16; i++) begin
			@(posedge CLK);
			if (HREADYOUT === 1'b1) break;
		end
		if (i == 16) hung();
	endtask
	// one single-word ahb transfer
	task xfer(input logic w, input logic [15:0] idx, input logic [31:0] d);
		@(posedge CLK);
		HADDR  <= {14'h0000, idx, 2'h0};
		HTRANS <= HTRANS_NONSEQ;
		HWRITE <= w;
		HSEL   <= 1'b1;
		rdy();
		HTRANS <= 2'h0;
		HSEL   <= 1'b0;
		HWDATA <= d;
		rdy();
		r = HRDATA;
	endtask
	task rd(input logic [15:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 32'h00000000);
		chk(r, exp);
	endtask
	// no reset pin activity for n cycles
	task quiet(input int n);
		logic bad;
		bad = 1'b0;
		repeat (n) begin
			@(posedge CLK);
			if (RST_PIN_N !== 1'b1) bad = 1'b1;
		end
		chk(bad, 1'b0);
	endtask
	// overflow due between lo and hi cycles, then pulse length
	task fire(input int lo, input int hi);
		int n;
		n = 0;
		while (RST_PIN_N !== 1'b0 && n < hi) begin
			@(posedge CLK);
			n++;
		end
		if (n == hi) hung();
		chk(n >= lo, 1'b1);
		n = 0;
		while (RST_PIN_N === 1'b0 && n < 64) begin
			@(posedge CLK);
			n++;
		end
		chk(n, 32);
	endtask
	task stop_pulse(input logic exp);
		@(posedge CLK);
		STOP_EXEC <= 1'b1;
		@(posedge CLK);
		STOP_EXEC <= 1'b0;
		#1 chk(ILLEGAL_OP_RST, exp);
	endtask
	// main sequence
	initial begin
		{CLK, RSTN, HWRITE, HSEL, STOP_EXEC, STOP_MODE, INTERNAL_RESET} = 7'h00;
		{TST_ON_RST_PIN, TST_ON_IRQ_PIN, MONITOR_MODE, MONITOR_BY_TST, BREAK_STATE} = 5'h00;
		{HADDR, HWDATA, HTRANS, err_count, total_checks} = 0;
		repeat (8) @(posedge CLK);
		RSTN <= 1'b1;
		rd(IDX_CONFIG, 32'h00000000);
		rd(IDX_CAUSE, 32'h00000000);
		rd(IDX_SERVICE, {24'h000000, VECTOR_LOW});
		chk(IRQ, 1'b0);
		$display("test reset values done");
		xfer(1'b1, IDX_IRQ_MASK, 32'h00000001);
		xfer(1'b1, IDX_CONFIG, 32'h00000001);
		xfer(1'b1, IDX_SERVICE, 32'h000000A5);
		fire(8100, 8300);
		rd(IDX_CAUSE, 32'h00000001);
		chk(IRQ, 1'b1);
		rd(IDX_IRQ_STAT, 32'h00000001);
		rd(IDX_IRQ_STAT, 32'h00000000);
		chk(IRQ, 1'b0);
		$display("test short overflow done");
		repeat (2) begin
			xfer(1'b1, IDX_SERVICE, 32'h0000005A);
			quiet(6000);
		end
		xfer(1'b1, IDX_SERVICE, 32'h000000FF);
		quiet(6000);
		rd(IDX_SERVICE, {24'h000000, VECTOR_LOW});
		fire(1000, 2400);
		$display("test service done");
		quiet(6000);
		INTERNAL_RESET <= 1'b1;
		@(posedge CLK);
		INTERNAL_RESET <= 1'b0;
		quiet(6000);
		xfer(1'b1, IDX_CONFIG, 32'h00000003);
		quiet(9000);
		xfer(1'b1, IDX_CONFIG, 32'h00000001);
		xfer(1'b1, IDX_SERVICE, 32'h00000000);
		$display("test internal reset and disable done");
		{MONITOR_MODE, MONITOR_BY_TST, TST_ON_IRQ_PIN} <= 3'h7;
		quiet(9000);
		xfer(1'b1, IDX_SERVICE, 32'h00000000);
		{MONITOR_MODE, MONITOR_BY_TST, TST_ON_IRQ_PIN} <= 3'h0;
		xfer(1'b1, IDX_SERVICE, 32'h00000000);
		{BREAK_STATE, TST_ON_RST_PIN} <= 2'h3;
		quiet(9000);
		xfer(1'b1, IDX_SERVICE, 32'h00000000);
		TST_ON_RST_PIN <= 1'b0;
		xfer(1'b1, IDX_SERVICE, 32'h00000000);
		fire(8150, 8185);
		BREAK_STATE <= 1'b0;
		$display("test monitor and break done");
		xfer(1'b1, IDX_SERVICE, 32'h00000000);
		STOP_MODE <= 1'b1;
		quiet(9000);
		STOP_MODE <= 1'b0;
		xfer(1'b1, IDX_SERVICE, 32'h00000000);
		stop_pulse(1'b1);
		xfer(1'b1, IDX_CONFIG, 32'h00000005);
		stop_pulse(1'b0);
		$display("test stop done");
		results();
	end
endmodule
